// ==== hdl/dual_pll_control_registers.v ====
// Control registers and control logic of the two-stage PLL clock generator
`include "pll_ctrl_defs.vh"

module dual_pll_control_registers (
    // Clock, reset and clock enable
    input  wire       clock,
    input  wire       arst_n,
    input  wire       clockEnable,
    // Serial control port register access
    input  wire [9:0] regAddr,
    input  wire       regWrite,
    input  wire [7:0] regWriteData,
    input  wire       regRead,
    output reg  [7:0] regReadData,
    output reg        regReadValid,
    // Reference and loop status inputs
    input  wire       refChoicePin,
    input  wire       primaryRefOk,
    input  wire       secondaryRefOk,
    input  wire       feedbackClkOk,
    input  wire       firstStageOscOk,
    input  wire       calDoneIn,
    // First-stage loop controls
    output wire       useSecondaryRef,
    output reg        tuneForceHalfSupply,
    output reg        tuneFollowPump,
    output wire       fastLockEnable,
    output wire [6:0] fastLockPumpCurrent,
    // Second-stage loop controls
    output wire [7:0] secondPumpCurrent,
    output wire [1:0] fineCount,
    output wire [5:0] coarseCount,
    output reg  [7:0] feedbackRatio,
    output reg        feedbackRatioLegal,
    output wire       lockDetectPowerDown,
    output wire       doublerEnable,
    output wire [1:0] pumpMode,
    output reg  [3:0] pumpModeSelect,
    // Oscillator controls
    output wire       predividerPathEnable,
    output wire       calDividerReset,
    output reg        secondRefValid,
    output wire       oscForceMidscale,
    output reg        calStart,
    output wire       calReset,
    output wire       calBusy,
    output wire       calDone
);

    // Calibration states
    localparam [2:0] CAL_IDLE = 3'b001;
    localparam [2:0] CAL_RUN  = 3'b010;
    localparam [2:0] CAL_DONE = 3'b100;

    // Register file: one entry per register, addressed by an index
    localparam       NUM_REGS = 6;
    localparam [2:0] IDX_NONE = 3'h7;
    localparam [8*NUM_REGS-1:0] REG_MASKS = {
        `MASK_OSC_CTRL, `MASK_SECOND_CTRL, `MASK_FB_DIVIDER,
        `MASK_PUMP_CURRENT, `MASK_FAST_LOCK, `MASK_REF_HOLD};
    localparam [8*NUM_REGS-1:0] REG_RESETS = {
        `RST_OSC_CTRL, `RST_SECOND_CTRL, `RST_FB_DIVIDER,
        `RST_PUMP_CURRENT, `RST_FAST_LOCK, `RST_REF_HOLD};

    reg  [2:0]            regIdx;
    wire [8*NUM_REGS-1:0] regFlat;

    // Named views of the register file entries
    wire [7:0] refHold_q     = regFlat[7:0];
    wire [7:0] fastLock_q    = regFlat[15:8];
    wire [7:0] pumpCurrent_q = regFlat[23:16];
    wire [7:0] fbDivider_q   = regFlat[31:24];
    wire [7:0] secondCtrl_q  = regFlat[39:32];
    wire [7:0] oscCtrl_q     = regFlat[47:40];

    // Calibration tracking
    reg        calBitPrev_q;
    reg  [2:0] calState_q;
    reg  [2:0] calState_d;
    reg  [7:0] readMux;

    wire       activeRefOk;
    wire       calEdge;

    // Offset to register index; unmapped offsets miss
    always @* begin
        case (regAddr)
            `OFF_REF_HOLD:     regIdx = 3'h0;
            `OFF_FAST_LOCK:    regIdx = 3'h1;
            `OFF_PUMP_CURRENT: regIdx = 3'h2;
            `OFF_FB_DIVIDER:   regIdx = 3'h3;
            `OFF_SECOND_CTRL:  regIdx = 3'h4;
            `OFF_OSC_CTRL:     regIdx = 3'h5;
            default:           regIdx = IDX_NONE;
        endcase
    end

    // Register entries; reserved bits masked off so they stay zero
    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g = g + 1) begin : g_entry
            reg [7:0] entry_q;
            always @(posedge clock or negedge arst_n) begin
                if (!arst_n)
                    entry_q <= REG_RESETS[8*g +: 8];
                else if (clockEnable && regWrite && {29'h0, regIdx} == g)
                    entry_q <= regWriteData & REG_MASKS[8*g +: 8];
            end
            assign regFlat[8*g +: 8] = entry_q;
        end
    endgenerate

    // Read multiplexer; unmapped offsets return zero
    always @* begin
        readMux = 8'h00;
        if (regIdx != IDX_NONE)
            readMux = regFlat[8*regIdx +: 8];
    end

    // Read data held until the next read
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            regReadData  <= 8'h00;
            regReadValid <= 1'b0;
        end else if (clockEnable) begin
            regReadValid <= regRead;
            if (regRead)
                regReadData <= readMux;
        end
    end

    // Reference choice for the first-stage loop
    reference_chooser u_chooser (
        .clock        (clock),
        .arst_n       (arst_n),
        .clockEnable  (clockEnable),
        .refMode      (refHold_q[2:0]),
        .refChoicePin (refChoicePin),
        .primaryOk    (primaryRefOk),
        .secondaryOk  (secondaryRefOk),
        .useSecondary (useSecondaryRef),
        .activeRefOk  (activeRefOk)
    );

    // Holdover: on clock loss either half supply or tristated pump
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tuneForceHalfSupply <= 1'b0;
            tuneFollowPump      <= 1'b0;
        end else if (clockEnable) begin
            tuneForceHalfSupply <= refHold_q[`BIT_HOLDOVER] &&
                                   !(feedbackClkOk && activeRefOk);
            tuneFollowPump      <= !refHold_q[`BIT_HOLDOVER] &&
                                   !(feedbackClkOk && activeRefOk);
        end
    end

    // First-stage fast lock fields
    assign fastLockEnable      = fastLock_q[`BIT_FAST_LOCK_EN];
    assign fastLockPumpCurrent = fastLock_q[6:0];

    // Second-stage pump current and divider fields
    assign secondPumpCurrent = pumpCurrent_q;
    assign fineCount         = fbDivider_q[7:6];
    assign coarseCount       = fbDivider_q[5:0];

    // Division ratio and its legality flag for software's benefit
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            feedbackRatio      <= 8'h00;
            feedbackRatioLegal <= 1'b0;
        end else if (clockEnable) begin
            feedbackRatio <= {fbDivider_q[5:0], 2'b00} +
                             {6'h00, fbDivider_q[7:6]};
            feedbackRatioLegal <= ({fbDivider_q[5:0], 2'b00} >=
                                   `FB_RATIO_MIN) &&
                                  (coarseCount >= 6'h07 ||
                                   (coarseCount >= 6'h05 &&
                                    fineCount <= 2'h2) ||
                                   (coarseCount == 6'h04 &&
                                    fineCount <= 2'h1));
        end
    end

    // Second-stage control fields
    assign lockDetectPowerDown = secondCtrl_q[`BIT_LOCK_DET_PD];
    assign doublerEnable       = secondCtrl_q[`BIT_DOUBLER_EN];
    assign pumpMode            = secondCtrl_q[1:0];

    // Pump mode decode: tristate, down, up, normal
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pumpModeSelect <= 4'h8;
        end else if (clockEnable) begin
            case (secondCtrl_q[1:0])
                `PUMP_TRISTATE: pumpModeSelect <= 4'h1;
                `PUMP_DOWN:     pumpModeSelect <= 4'h2;
                `PUMP_UP:       pumpModeSelect <= 4'h4;
                default:        pumpModeSelect <= 4'h8;
            endcase
        end
    end

    // Oscillator control fields
    assign predividerPathEnable = oscCtrl_q[`BIT_PATH_EN];
    assign calDividerReset      = oscCtrl_q[`BIT_CAL_DIV_RST];
    assign oscForceMidscale     = oscCtrl_q[`BIT_FORCE_MID];
    assign calReset             = !oscCtrl_q[`BIT_CAL_START];

    // Second-stage reference validity with override
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n)
            secondRefValid <= 1'b0;
        else if (clockEnable)
            secondRefValid <= oscCtrl_q[`BIT_REF_VALID_OVR] ||
                              firstStageOscOk;
    end

    // Rising edge of the calibrate bit; a held one never restarts
    assign calEdge = oscCtrl_q[`BIT_CAL_START] && !calBitPrev_q;

    // Calibration sequencing
    always @* begin
        calState_d = calState_q;
        case (calState_q)
            CAL_IDLE: begin
                if (calEdge)
                    calState_d = CAL_RUN;
            end
            CAL_RUN: begin
                if (!oscCtrl_q[`BIT_CAL_START])
                    calState_d = CAL_IDLE;
                else if (calDoneIn)
                    calState_d = CAL_DONE;
            end
            CAL_DONE: begin
                if (!oscCtrl_q[`BIT_CAL_START])
                    calState_d = CAL_IDLE;
            end
            default: calState_d = CAL_IDLE;
        endcase
    end

    // Calibration state and start pulse; the bit itself is left alone
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            calBitPrev_q <= 1'b0;
            calState_q   <= CAL_IDLE;
            calStart     <= 1'b0;
        end else if (clockEnable) begin
            calBitPrev_q <= oscCtrl_q[`BIT_CAL_START];
            calState_q   <= calState_d;
            calStart     <= calEdge && calState_q[0];
        end
    end

    // Calibration status
    assign calBusy = calState_q[1];
    assign calDone = calState_q[2];

endmodule // dual_pll_control_registers

// ==== hdl/pll_ctrl_defs.vh ====
// Register offsets, field positions and reset values for the PLL control
`ifndef PLL_CTRL_DEFS_VH
`define PLL_CTRL_DEFS_VH

// Register offsets on the serial control port
`define ADDR_W            10
`define OFF_REF_HOLD      10'h10a
`define OFF_FAST_LOCK     10'h10b
`define OFF_PUMP_CURRENT  10'h200
`define OFF_FB_DIVIDER    10'h201
`define OFF_SECOND_CTRL   10'h202
`define OFF_OSC_CTRL      10'h203

// Writable-bit masks; reserved bits read zero
`define MASK_REF_HOLD     8'h0f
`define MASK_FAST_LOCK    8'hff
`define MASK_PUMP_CURRENT 8'hff
`define MASK_FB_DIVIDER   8'hff
`define MASK_SECOND_CTRL  8'ha3
`define MASK_OSC_CTRL     8'h1f

// Reset values
`define RST_REF_HOLD      8'h00
`define RST_FAST_LOCK     8'h00
`define RST_PUMP_CURRENT  8'h00
`define RST_FB_DIVIDER    8'h00
`define RST_SECOND_CTRL   8'h03
`define RST_OSC_CTRL      8'h00

// Reference select / holdover fields
`define BIT_HOLDOVER      3
`define BIT_REF_PIN_MODE  2
`define REF_NONREVERT     2'h0
`define REF_REVERT        2'h1
`define REF_FORCE_PRI     2'h2
`define REF_FORCE_SEC     2'h3

// Fast lock fields
`define BIT_FAST_LOCK_EN  7

// Second-stage control fields
`define BIT_LOCK_DET_PD   7
`define BIT_DOUBLER_EN    5
`define PUMP_TRISTATE     2'h0
`define PUMP_DOWN         2'h1
`define PUMP_UP           2'h2
`define PUMP_NORMAL       2'h3

// Oscillator control fields
`define BIT_PATH_EN       4
`define BIT_CAL_DIV_RST   3
`define BIT_REF_VALID_OVR 2
`define BIT_FORCE_MID     1
`define BIT_CAL_START     0

// Feedback division legal limits
`define FB_RATIO_MIN      8'h10
`define FB_RATIO_MAX      8'hff

`endif

// ==== hdl/reference_chooser.v ====
// Primary/secondary reference choice for the first-stage loop
`include "pll_ctrl_defs.vh"

module reference_chooser (
    // Clock and reset
    input  wire       clock,
    input  wire       arst_n,
    input  wire       clockEnable,
    // Mode and inputs
    input  wire [2:0] refMode,
    input  wire       refChoicePin,
    input  wire       primaryOk,
    input  wire       secondaryOk,
    // Result
    output wire       useSecondary,
    output wire       activeRefOk
);

    localparam [1:0] ON_PRIMARY   = 2'b01;
    localparam [1:0] ON_SECONDARY = 2'b10;

    reg [1:0] state_q;
    reg [1:0] state_d;

    // Next reference from mode, pin and validity
    always @* begin
        state_d = state_q;
        if (refMode[`BIT_REF_PIN_MODE]) begin
            state_d = refChoicePin ? ON_SECONDARY : ON_PRIMARY;
        end else begin
            case (refMode[1:0])
                `REF_FORCE_PRI: state_d = ON_PRIMARY;
                `REF_FORCE_SEC: state_d = ON_SECONDARY;
                `REF_REVERT: begin
                    // Go back to primary as soon as it is good
                    if (primaryOk)
                        state_d = ON_PRIMARY;
                    else if (secondaryOk)
                        state_d = ON_SECONDARY;
                end
                default: begin
                    // Nonrevertive: leave a reference only on its loss
                    case (state_q)
                        ON_PRIMARY: begin
                            if (!primaryOk && secondaryOk)
                                state_d = ON_SECONDARY;
                        end
                        ON_SECONDARY: begin
                            if (!secondaryOk && primaryOk)
                                state_d = ON_PRIMARY;
                        end
                        default: state_d = ON_PRIMARY;
                    endcase
                end
            endcase
        end
    end

    // State register
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n)
            state_q <= ON_PRIMARY;
        else if (clockEnable)
            state_q <= state_d;
    end

    assign useSecondary = state_q[1];
    assign activeRefOk  = state_q[1] ? secondaryOk : primaryOk;

endmodule // reference_chooser

// ==== sim/pll_ctrl_assertions.sv ====
// Port-level assertions for the PLL control register block
module pll_ctrl_assertions (
    // Clock and reset
    input logic       clock,
    input logic       arst_n,
    input logic       clockEnable,
    // Register port
    input logic [9:0] regAddr,
    input logic       regRead,
    input logic [7:0] regReadData,
    input logic       regReadValid,
    // Status and controls
    input logic       feedbackClkOk,
    input logic       firstStageOscOk,
    input logic       tuneForceHalfSupply,
    input logic       tuneFollowPump,
    input logic [1:0] fineCount,
    input logic [5:0] coarseCount,
    input logic [7:0] feedbackRatio,
    input logic [1:0] pumpMode,
    input logic [3:0] pumpModeSelect,
    input logic       secondRefValid,
    input logic       calStart,
    input logic       calReset
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    // Read accepted on this edge
    logic readGo;
    assign readGo = regRead && clockEnable;
    sequence readTaken;
        readGo;
    endsequence
    sequence unmappedRead;
        readTaken ##0 !(regAddr inside {10'h10a, 10'h10b, [10'h200:10'h203]});
    endsequence
    // Calibrate bit went from zero to one two samples back
    sequence calArmedRise;
        !calReset ##0 $past(calReset, 2);
    endsequence

    read_valid_next_a: assert property (readTaken |=> regReadValid)
        else $error("read valid missing after read");
    valid_without_read_a: assert property (clockEnable && !regRead
        |=> !regReadValid) else $error("read valid without read");
    read_data_hold_a: assert property (!readGo |=> $stable(regReadData))
        else $error("read data changed without read");
    unmapped_read_zero_a: assert property (
        unmappedRead |=> regReadData == 8'h00)
        else $error("unmapped read not zero");
    holdover_choice_a: assert property (
        clockEnable && !feedbackClkOk
        |=> tuneForceHalfSupply != tuneFollowPump)
        else $error("holdover outputs wrong on clock failure");
    pump_one_hot_a: assert property (
        $stable(pumpMode)[*2] |-> pumpModeSelect == (4'h1 << pumpMode))
        else $error("pump mode select mismatch");
    ratio_sum_a: assert property (
        $stable({coarseCount, fineCount})[*2]
        |-> feedbackRatio == {coarseCount, 2'b00} + {6'h00, fineCount})
        else $error("feedback ratio mismatch");
    ref_valid_osc_a: assert property (
        clockEnable && firstStageOscOk |=> secondRefValid)
        else $error("reference valid not set");
    cal_start_edge_a: assert property (calStart |-> calArmedRise)
        else $error("calibration start without rising bit");
    cal_pulse_once_a: assert property (calStart |=> !calStart)
        else $error("calibration start longer than one cycle");
endmodule // pll_ctrl_assertions

bind dual_pll_control_registers pll_ctrl_assertions u_checker (
    .clock, .arst_n, .clockEnable, .regAddr, .regRead, .regReadData,
    .regReadValid, .feedbackClkOk, .firstStageOscOk, .tuneForceHalfSupply,
    .tuneFollowPump, .fineCount, .coarseCount, .feedbackRatio, .pumpMode,
    .pumpModeSelect, .secondRefValid, .calStart, .calReset);

// ==== sim/testbench.sv ====
// Self-checking bench for the PLL control register block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // Clock, reset and register port
    logic       clock = 0, arst_n = 0, clockEnable = 1;
    logic [9:0] regAddr = 0;
    logic       regWrite = 0, regRead = 0, regReadValid;
    logic [7:0] regWriteData = 0, regReadData;
    // Status inputs
    logic       refChoicePin = 0, primaryRefOk = 1, secondaryRefOk = 1;
    logic       feedbackClkOk = 1, firstStageOscOk = 1, calDoneIn = 0;
    // Control outputs
    logic       useSecondaryRef, tuneForceHalfSupply, tuneFollowPump;
    logic       fastLockEnable, feedbackRatioLegal, lockDetectPowerDown;
    logic       doublerEnable, predividerPathEnable, calDividerReset;
    logic       secondRefValid, oscForceMidscale, calStart, calReset;
    logic       calBusy, calDone;
    logic [6:0] fastLockPumpCurrent;
    logic [7:0] secondPumpCurrent, feedbackRatio, d;
    logic [1:0] fineCount, pumpMode, m;
    logic [5:0] coarseCount;
    logic [3:0] pumpModeSelect;
    int         error_cnt = 0, total_checks = 0, calPulses = 0, i;
    // Register map, reset values and writable masks
    logic [9:0] offs [6] = '{10'h10a, 10'h10b, 10'h200, 10'h201, 10'h202,
                             10'h203};
    logic [7:0] rsts [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00};
    logic [7:0] masks [6] = '{8'h0f, 8'hff, 8'hff, 8'hff, 8'ha3, 8'h1f};
    logic [7:0] divs [8] = '{8'hc7, 8'h04, 8'h44, 8'h84, 8'h03, 8'h86,
                             8'hc6, 8'hff};
    logic       legal [8] = '{1, 1, 1, 0, 0, 1, 0, 1};

    dual_pll_control_registers u_dut (
        .clock, .arst_n, .clockEnable, .regAddr, .regWrite, .regWriteData,
        .regRead, .regReadData, .regReadValid, .refChoicePin, .primaryRefOk,
        .secondaryRefOk, .feedbackClkOk, .firstStageOscOk, .calDoneIn,
        .useSecondaryRef, .tuneForceHalfSupply, .tuneFollowPump,
        .fastLockEnable, .fastLockPumpCurrent, .secondPumpCurrent,
        .fineCount, .coarseCount, .feedbackRatio, .feedbackRatioLegal,
        .lockDetectPowerDown, .doublerEnable, .pumpMode, .pumpModeSelect,
        .predividerPathEnable, .calDividerReset, .secondRefValid,
        .oscForceMidscale, .calStart, .calReset, .calBusy, .calDone);

    // 50 MHz clock
    always #10 clock = ~clock;
    // Count calibration start pulses
    always @(posedge clock) if (calStart === 1'b1) calPulses++;

    task automatic test_done;
        $display("Checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] exp, got);
        total_checks++;
        if (exp !== got) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Wait edges, then settle past the edge
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] v);
        regAddr = a;
        regWriteData = v;
        regWrite = 1;
        step(1);
        regWrite = 0;
        step(1); // Idle edge between strobes
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        int n;
        n = 0;
        regAddr = a;
        regRead = 1;
        step(1);
        regRead = 0;
        while (regReadValid !== 1'b1 && n < 4) begin
            step(1);
            n++;
        end
        if (regReadValid !== 1'b1) begin
            error_cnt++;
            $display("Error read valid expected 1 seen 0");
            test_done();
        end else begin
            check("read data", exp, regReadData);
            step(1);
        end
    endtask

    // Main sequence
    initial begin
        step(8);
        arst_n = 1;
        step(1);
        for (i = 0; i < 6; i++) rd(offs[i], rsts[i]);
        for (i = 0; i < 6; i++) begin
            wr(offs[i], (offs[i] == 10'h202) ? 8'hbf : 8'hff);
            rd(offs[i], masks[i]);
        end
        wr(10'h000, 8'h55);
        rd(10'h000, 8'h00);
        rd(10'h204, 8'h00);
        check("cal pulses", 8'd1, 8'(calPulses));
        wr(10'h203, 8'h01);
        step(2);
        check("cal pulses", 8'd1, 8'(calPulses));
        calDoneIn = 1;
        step(3);
        check("calDone", 1, calDone);
        rd(10'h203, 8'h01);
        wr(10'h203, 8'h00);
        calDoneIn = 0;
        check("calReset", 1, calReset);
        wr(10'h203, 8'h01);
        step(2);
        check("cal pulses", 8'd2, 8'(calPulses));
        check("calBusy", 1, calBusy);
        wr(10'h10b, 8'ha5);
        check("fastLockEnable", 1, fastLockEnable);
        check("fastLockPumpCurrent", 8'h25, fastLockPumpCurrent);
        wr(10'h200, 8'h5a);
        check("secondPumpCurrent", 8'h5a, secondPumpCurrent);
        for (i = 0; i < 8; i++) begin
            d = divs[i];
            wr(10'h201, d);
            step(1);
            check("fineCount", d[7:6], fineCount);
            check("coarseCount", d[5:0], coarseCount);
            check("ratio", {d[5:0], 2'b00} + d[7:6], feedbackRatio);
            check("ratioLegal", legal[i], feedbackRatioLegal);
        end
        for (i = 0; i < 4; i++) begin
            m = i[1:0];
            wr(10'h202, {m[0], 1'b0, m[1], 3'b000, m});
            step(1);
            check("lockDetectPowerDown", m[0], lockDetectPowerDown);
            check("doublerEnable", m[1], doublerEnable);
            check("pumpMode", m, pumpMode);
            check("pumpModeSelect", 4'h1 << m, pumpModeSelect);
        end
        firstStageOscOk = 0;
        wr(10'h203, 8'h1e);
        step(1);
        check("pathEnable", 1, predividerPathEnable);
        check("calDividerReset", 1, calDividerReset);
        check("secondRefValid", 1, secondRefValid);
        check("oscForceMidscale", 1, oscForceMidscale);
        wr(10'h203, 8'h00);
        step(1);
        check("secondRefValid", 0, secondRefValid);
        check("oscForceMidscale", 0, oscForceMidscale);
        check("pathEnable", 0, predividerPathEnable);
        check("calDividerReset", 0, calDividerReset);
        firstStageOscOk = 1;
        // Forced, nonrevertive, revertive and pin-driven choices
        wr(10'h10a, 8'h03);
        step(2);
        check("useSecondaryRef", 1, useSecondaryRef);
        wr(10'h10a, 8'h00);
        step(2);
        check("useSecondaryRef", 1, useSecondaryRef);
        secondaryRefOk = 0;
        step(3);
        check("useSecondaryRef", 0, useSecondaryRef);
        secondaryRefOk = 1;
        wr(10'h10a, 8'h03);
        step(2);
        wr(10'h10a, 8'h01);
        step(3);
        check("useSecondaryRef", 0, useSecondaryRef);
        wr(10'h10a, 8'h06);
        refChoicePin = 1;
        step(2);
        check("useSecondaryRef", 1, useSecondaryRef);
        wr(10'h10a, 8'h07);
        refChoicePin = 0;
        step(2);
        check("useSecondaryRef", 0, useSecondaryRef);
        // Holdover on feedback clock loss
        wr(10'h10a, 8'h0a);
        feedbackClkOk = 0;
        step(2);
        check("tuneForceHalfSupply", 1, tuneForceHalfSupply);
        check("tuneFollowPump", 0, tuneFollowPump);
        wr(10'h10a, 8'h02);
        step(2);
        check("tuneFollowPump", 1, tuneFollowPump);
        check("tuneForceHalfSupply", 0, tuneForceHalfSupply);
        feedbackClkOk = 1;
        // Writes are frozen while the clock enable is low
        clockEnable = 0;
        wr(10'h200, 8'h33);
        clockEnable = 1;
        rd(10'h200, 8'h5a);
        test_done();
    end
endmodule // testbench
